// ==== caf_pkg.sv ====
// caf_pkg: constants, field layouts and carrier types of the
// can acceptance filter and bit timing block.
// assumes a 32-bit apb slave with byte addresses, one word per register.
//
// Summary of operation
// - compare received identifiers with masked patterns
// - set full flag and lowest hit index
// - 32-bit mode gives two filters
// - 16-bit mode gives four filters
// - 8-bit mode gives eight filters
// - closed mode never accepts any message
// - mask zero compares, mask one ignores
// - accept once when any filter matches
// - error counters ignore all writes
// - configuration writable only in initialization mode
// - transmit pin recessive in init/power-down
// - module enable takes first write only outside special mode
// - clock source bit picks core clock
// - prescaler makes quantum, bit sums segments
// - sync segment lasts exactly one quantum
// - segment one spans four to sixteen quanta; code allows one to sixteen
// - segment two spans two to eight quanta; code allows one to eight
// - transmit at transmit point, sample at sample point
// - jump width spans one to four quanta
// - timing fields hold length minus one
// - accepted message moves to foreground, sets flag
package caf_pkg;
	// register byte offsets
	localparam logic [7:0] CAF_OFS_CTL0 = 8'h00;
	localparam logic [7:0] CAF_OFS_CTL1 = 8'h04;
	localparam logic [7:0] CAF_OFS_BTR0 = 8'h08;
	localparam logic [7:0] CAF_OFS_BTR1 = 8'h0C;
	localparam logic [7:0] CAF_OFS_IDAC = 8'h10;
	localparam logic [7:0] CAF_OFS_RFLG = 8'h14;
	localparam logic [7:0] CAF_OFS_ERRC = 8'h18;
	localparam logic [7:0] CAF_OFS_FGID = 8'h1C;
	localparam logic [7:0] CAF_OFS_ACC = 8'h20;
	localparam logic [7:0] CAF_OFS_MSK = 8'h40;
	localparam logic [7:0] CAF_OFS_ARR_SPAN = 8'h20;
	// bit positions and field layouts
	localparam int CAF_CTL0_INIT_REQ_BIT = 0;
	localparam int CAF_CTL1_INIT_ACK_BIT = 0;
	localparam int CAF_CTL1_CLOCK_SOURCE_SELECT_BIT = 6;
	localparam int CAF_CTL1_ENABLE_BIT = 7;
	localparam int CAF_BTR0_PRESC_LSB = 0;
	localparam int CAF_BTR0_SJW_LSB = 6;
	localparam int CAF_BTR1_TIME_SEGMENT_ONE_FIELD_LSB = 0;
	localparam int CAF_BTR1_TIME_SEGMENT_TWO_FIELD_LSB = 4;
	localparam int CAF_BTR1_SAMP_BIT = 7;
	localparam int CAF_IDAC_HIT_LSB = 0;
	localparam int CAF_IDAC_MODE_LSB = 4;
	localparam int CAF_RFLG_FULL_BIT = 0;
	localparam int CAF_ERRC_TX_LSB = 8;
	// reset values: block leaves reset in initialization mode
	localparam logic [7:0] CAF_CTL0_RST = 8'h01;
	localparam logic [7:0] CAF_CTL1_RST = 8'h00;
	localparam logic [7:0] CAF_BTR_RST = 8'h00;
	localparam logic [7:0] CAF_IDAC_RST = 8'h00;
	localparam logic [7:0] CAF_BYTE_ZERO = 8'h00;
	localparam logic RECESSIVE = 1'b1;
	// filter modes
	typedef enum logic [1:0] {
		CAF_MODE_32 = 2'b00,
		CAF_MODE_16 = 2'b01,
		CAF_MODE_8 = 2'b10,
		CAF_MODE_CLOSED = 2'b11
	} caf_mode_t;
	// received frame from the protocol engine
	typedef struct packed {
		logic ide;
		logic rtr;
		logic srr;
		logic [28:0] id;
	} caf_frame_t;
	// bit timing segments
	typedef enum logic [2:0] {
		CAF_SEG_SYNC = 3'b001,
		CAF_SEG_ONE = 3'b010,
		CAF_SEG_TWO = 3'b100
	} caf_seg_t;
endpackage

// ==== caf_top.sv ====
// caf_top: acceptance filter, configuration lock and bit timing.
// assumes an apb master, a protocol engine delivering frames and tx bits,
// and a synchronous receive pin.
`timescale 1ns/1ps
`default_nettype none
module caf_top
	import caf_pkg::*;
#(
	parameter int PRESC_W = 6,
	parameter int NUM_FILT_BYTES = 8
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// system side
	input wire logic i_osc_tick,
	input wire logic i_special_mode,
	input wire logic i_power_down,
	input wire logic i_bus_idle,
	// protocol engine side
	input wire logic i_rx_done,
	input wire caf_frame_t i_rx_frame,
	input wire logic [7:0] i_rx_err_cnt,
	input wire logic [7:0] i_tx_err_cnt,
	input wire logic i_tx_bit,
	output logic o_tx_point,
	output logic o_sample_point,
	output logic o_rx_bit,
	output caf_frame_t o_fg_frame,
	// can pins
	input wire logic i_can_rx,
	output logic o_can_tx
);
	// elaboration checks
	if (PRESC_W < 1 || PRESC_W > 6) begin : g_bad_presc
		$error("PRESC_W must be 1 to 6");
	end
	if (NUM_FILT_BYTES != 8) begin : g_bad_filt
		$error("NUM_FILT_BYTES must be 8");
	end

	// identifier image in register byte order, byte 0 at the top
	function automatic logic [31:0] id_image(input caf_frame_t f);
		logic [31:0] img;
		img = '0;
		if (f.ide) begin
			img = {f.id[28:21], f.id[20:18], f.srr, f.ide, f.id[17:15],
				f.id[14:7], f.id[6:0], f.rtr};
		end else begin
			img = {f.id[10:3], f.id[2:0], f.rtr, f.ide, 3'b000, 16'h0000};
		end
		return img;
	endfunction

	// masked byte compare: zero mask bits compare, one bits ignore
	function automatic logic byte_hit(input logic [7:0] id_b,
		input logic [7:0] acc_b, input logic [7:0] msk_b);
		return ~|((id_b ^ acc_b) & ~msk_b);
	endfunction

	// majority of three samples
	function automatic logic maj3(input logic [2:0] s);
		return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction

	// registers
	logic [7:0] ctl0_reg; // init request lives here
	logic init_ack_reg; // acknowledge of initialization mode
	logic clock_source_select_reg; // 1: bus clock, 0: oscillator
	logic enable_reg; // module enable
	logic enable_wr_reg; // first write to enable already taken
	logic [7:0] btr0_reg;
	logic [7:0] btr1_reg;
	logic [1:0] mode_reg;
	logic [2:0] hit_reg;
	logic rxf_reg;
	logic [7:0] acc_reg [NUM_FILT_BYTES];
	logic [7:0] msk_reg [NUM_FILT_BYTES];
	caf_frame_t fg_reg;

	// apb decode
	wire apb_wr = i_psel & i_penable & i_pwrite;
	wire [2:0] arr_idx = i_paddr[4:2];
	wire sel_acc = (i_paddr >= CAF_OFS_ACC) &&
		(i_paddr < CAF_OFS_ACC + CAF_OFS_ARR_SPAN);
	wire sel_msk = (i_paddr >= CAF_OFS_MSK) &&
		(i_paddr < CAF_OFS_MSK + CAF_OFS_ARR_SPAN);
	wire sel_fix = (i_paddr == CAF_OFS_CTL0) || (i_paddr == CAF_OFS_CTL1) ||
		(i_paddr == CAF_OFS_BTR0) || (i_paddr == CAF_OFS_BTR1) ||
		(i_paddr == CAF_OFS_IDAC) || (i_paddr == CAF_OFS_RFLG) ||
		(i_paddr == CAF_OFS_ERRC) || (i_paddr == CAF_OFS_FGID);
	wire addr_ok = sel_fix | sel_acc | sel_msk;
	wire unaligned = |i_paddr[1:0];
	wire init_req = ctl0_reg[CAF_CTL0_INIT_REQ_BIT];
	wire cfg_open = init_req & init_ack_reg;
	wire wr_ok = apb_wr & addr_ok & ~unaligned;
	wire wr_ctl0 = wr_ok && (i_paddr == CAF_OFS_CTL0);
	wire wr_ctl1 = wr_ok && (i_paddr == CAF_OFS_CTL1);
	wire wr_btr0 = wr_ok && (i_paddr == CAF_OFS_BTR0) && cfg_open;
	wire wr_btr1 = wr_ok && (i_paddr == CAF_OFS_BTR1) && cfg_open;
	wire wr_idac = wr_ok && (i_paddr == CAF_OFS_IDAC) && cfg_open;
	wire wr_rflg = wr_ok && (i_paddr == CAF_OFS_RFLG);
	wire wr_acc = wr_ok && sel_acc && cfg_open;
	wire wr_msk = wr_ok && sel_msk && cfg_open;
	// enable accepts one write unless in special mode
	wire en_wr_ok = wr_ctl1 & (~enable_wr_reg | i_special_mode);

	// apb answer: no wait states, error on unmapped or unaligned address
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel & i_penable & (~addr_ok | unaligned);

	// read mux; error counters are read only views
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = '0;
		if (sel_acc) begin
			rd_mux[7:0] = acc_reg[arr_idx];
		end else if (sel_msk) begin
			rd_mux[7:0] = msk_reg[arr_idx];
		end else begin
			unique case (i_paddr)
				CAF_OFS_CTL0: rd_mux[7:0] = ctl0_reg;
				CAF_OFS_CTL1: begin
					rd_mux[CAF_CTL1_INIT_ACK_BIT] = init_ack_reg;
					rd_mux[CAF_CTL1_CLOCK_SOURCE_SELECT_BIT] = clock_source_select_reg;
					rd_mux[CAF_CTL1_ENABLE_BIT] = enable_reg;
				end
				CAF_OFS_BTR0: rd_mux[7:0] = btr0_reg;
				CAF_OFS_BTR1: rd_mux[7:0] = btr1_reg;
				CAF_OFS_IDAC: begin
					rd_mux[CAF_IDAC_MODE_LSB +: 2] = mode_reg;
					rd_mux[CAF_IDAC_HIT_LSB +: 3] = hit_reg;
				end
				CAF_OFS_RFLG: rd_mux[CAF_RFLG_FULL_BIT] = rxf_reg;
				CAF_OFS_ERRC: rd_mux[15:0] = {i_tx_err_cnt, i_rx_err_cnt};
				CAF_OFS_FGID: rd_mux = fg_reg;
				default: rd_mux = '0;
			endcase
		end
	end
	assign o_prdata = rd_mux;

	// control registers; ctl0 never locked
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			ctl0_reg <= CAF_CTL0_RST;
			clock_source_select_reg <= 1'b0;
			enable_reg <= 1'b0;
			enable_wr_reg <= 1'b0;
		end else begin
			if (wr_ctl0) begin
				ctl0_reg <= i_pwdata[7:0];
			end
			// clock source only changes in initialization mode
			if (wr_ctl1 && cfg_open) begin
				clock_source_select_reg <= i_pwdata[CAF_CTL1_CLOCK_SOURCE_SELECT_BIT];
			end
			if (en_wr_ok) begin
				enable_reg <= i_pwdata[CAF_CTL1_ENABLE_BIT];
				enable_wr_reg <= 1'b1;
			end
		end
	end

	// init acknowledge follows request once the bus is idle
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			init_ack_reg <= 1'b0;
		end else begin
			init_ack_reg <= init_req & (init_ack_reg | i_bus_idle);
		end
	end

	// timing and filter configuration, writable only when open
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			btr0_reg <= CAF_BTR_RST;
			btr1_reg <= CAF_BTR_RST;
			mode_reg <= CAF_IDAC_RST[CAF_IDAC_MODE_LSB +: 2];
			for (int i = 0; i < NUM_FILT_BYTES; i++) begin
				acc_reg[i] <= CAF_BYTE_ZERO;
				msk_reg[i] <= CAF_BYTE_ZERO;
			end
		end else begin
			if (wr_btr0) begin
				btr0_reg <= i_pwdata[7:0];
			end
			if (wr_btr1) begin
				btr1_reg <= i_pwdata[7:0];
			end
			if (wr_idac) begin
				mode_reg <= i_pwdata[CAF_IDAC_MODE_LSB +: 2];
			end
			if (wr_acc) begin
				acc_reg[arr_idx] <= i_pwdata[7:0];
			end
			if (wr_msk) begin
				msk_reg[arr_idx] <= i_pwdata[7:0];
			end
		end
	end

	// identifier image of the received frame
	wire [31:0] img = id_image(i_rx_frame);
	// per byte masked matches against each image byte position
	logic [7:0] m32;
	logic [7:0] m16;
	logic [7:0] m8;
	logic [7:0] hits;
	always_comb begin
		for (int b = 0; b < NUM_FILT_BYTES; b++) begin
			m32[b] = byte_hit(img[31 - 8 * (b % 4) -: 8], acc_reg[b],
				msk_reg[b]);
			m16[b] = byte_hit(img[31 - 8 * (b % 2) -: 8], acc_reg[b],
				msk_reg[b]);
			m8[b] = byte_hit(img[31:24], acc_reg[b], msk_reg[b]);
		end
		hits = '0;
		unique case (caf_mode_t'(mode_reg))
			// two filters, one per bank of four bytes
			CAF_MODE_32: hits[1:0] = {&m32[7:4], &m32[3:0]};
			// four filters, byte pairs of each bank
			CAF_MODE_16: hits[3:0] = {&m16[7:6], &m16[5:4], &m16[3:2],
				&m16[1:0]};
			// eight filters on the first identifier byte
			CAF_MODE_8: hits = m8;
			CAF_MODE_CLOSED: hits = '0;
		endcase
	end

	logic [2:0] hit_idx;
	always_comb begin
		hit_idx = '0;
		for (int k = NUM_FILT_BYTES - 1; k >= 0; k--) begin
			if (hits[k]) begin
				hit_idx = 3'(k);
			end
		end
	end
	// any hit accepts, once; full foreground holds off the shift
	wire accept = i_rx_done & (|hits) & ~rxf_reg & ~init_ack_reg;
	wire rxf_clr = wr_rflg & i_pwdata[CAF_RFLG_FULL_BIT];

	// accepted frame moves to the foreground buffer
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rxf_reg <= 1'b0;
			hit_reg <= CAF_IDAC_RST[CAF_IDAC_HIT_LSB +: 3];
			fg_reg <= '0;
		end else begin
			// set wins over a clear in the same cycle
			rxf_reg <= accept | (rxf_reg & ~rxf_clr);
			if (accept) begin
				hit_reg <= hit_idx;
				fg_reg <= i_rx_frame;
			end
		end
	end
	assign o_fg_frame = fg_reg;

	// timing fields
	wire [PRESC_W-1:0] presc = btr0_reg[CAF_BTR0_PRESC_LSB +: PRESC_W];
	wire [1:0] sjw = btr0_reg[CAF_BTR0_SJW_LSB +: 2];
	wire [3:0] time_segment_one_field = btr1_reg[CAF_BTR1_TIME_SEGMENT_ONE_FIELD_LSB +: 4];
	wire [2:0] time_segment_two_field = btr1_reg[CAF_BTR1_TIME_SEGMENT_TWO_FIELD_LSB +: 3];
	wire samp3 = btr1_reg[CAF_BTR1_SAMP_BIT];
	wire run = enable_reg & ~init_ack_reg & ~i_power_down;
	// core clock enable from oscillator tick or every bus cycle
	wire core_tick = run & (clock_source_select_reg | i_osc_tick);

	// prescaler: one quantum per presc+1 core ticks
	logic [PRESC_W-1:0] presc_cnt_reg;
	wire tq_tick = core_tick && (presc_cnt_reg == presc);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			presc_cnt_reg <= '0;
		end else if (!run || tq_tick) begin
			presc_cnt_reg <= '0;
		end else if (core_tick) begin
			presc_cnt_reg <= presc_cnt_reg + 1'b1;
		end
	end

	// falling edge detect on the receive pin, held to the next quantum
	logic rx_prev_reg;
	logic edge_reg;
	wire rx_fall = rx_prev_reg & ~i_can_rx;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_prev_reg <= RECESSIVE;
			edge_reg <= 1'b0;
		end else begin
			rx_prev_reg <= i_can_rx;
			edge_reg <= rx_fall | (edge_reg & ~tq_tick);
		end
	end
	wire edge_now = edge_reg | rx_fall;

	// bit timing state
	caf_seg_t seg_reg;
	logic [4:0] cnt_reg;
	logic [4:0] seg1_end_reg;
	logic [2:0] samp_sh_reg;
	// segment one ends at its field value plus any lengthening
	wire seg1_last = (seg_reg == CAF_SEG_ONE) && (cnt_reg == seg1_end_reg);
	// segment two ends at its field value
	wire seg2_last = (seg_reg == CAF_SEG_TWO) && (cnt_reg == 5'(time_segment_two_field));
	// jump width in quanta is field plus one
	wire [4:0] sjw_q = 5'(sjw) + 5'd1;
	wire [4:0] late_err = cnt_reg + 5'd1;
	wire [4:0] seg2_left = 5'(time_segment_two_field) - cnt_reg;

	// segment sequencer: sync, segment one, segment two
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			seg_reg <= CAF_SEG_SYNC;
			cnt_reg <= '0;
			seg1_end_reg <= '0;
		end else if (!run) begin
			seg_reg <= CAF_SEG_SYNC;
			cnt_reg <= '0;
		end else if (tq_tick) begin
			unique case (seg_reg)
				// sync segment is always one quantum
				CAF_SEG_SYNC: begin
					seg_reg <= CAF_SEG_ONE;
					cnt_reg <= '0;
					seg1_end_reg <= 5'(time_segment_one_field);
				end
				CAF_SEG_ONE: begin
					if (seg1_last) begin
						seg_reg <= CAF_SEG_TWO;
						cnt_reg <= '0;
					end else begin
						cnt_reg <= cnt_reg + 5'd1;
					end
					// late edge lengthens segment one by up to sjw
					if (edge_now && !seg1_last) begin
						seg1_end_reg <= seg1_end_reg +
							((late_err < sjw_q) ? late_err : sjw_q);
					end
				end
				CAF_SEG_TWO: begin
					// early edge shortens segment two within sjw
					if (seg2_last || (edge_now && seg2_left <= sjw_q)) begin
						seg_reg <= CAF_SEG_SYNC;
						cnt_reg <= '0;
					end else begin
						cnt_reg <= cnt_reg + 5'd1;
					end
				end
			endcase
		end
	end

	// sampling: single or majority of the last three quanta
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			samp_sh_reg <= {3{RECESSIVE}};
			o_rx_bit <= RECESSIVE;
			o_sample_point <= 1'b0;
		end else begin
			o_sample_point <= tq_tick & seg1_last;
			if (tq_tick && seg_reg == CAF_SEG_ONE) begin
				samp_sh_reg <= {samp_sh_reg[1:0], i_can_rx};
			end
			if (tq_tick && seg1_last) begin
				o_rx_bit <= samp3 ? maj3({samp_sh_reg[1:0], i_can_rx})
					: i_can_rx;
			end
		end
	end

	// transmit point at the end of each sync quantum
	logic tx_bit_reg;
	wire tx_pt = tq_tick & (seg_reg == CAF_SEG_SYNC);
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_bit_reg <= RECESSIVE;
			o_tx_point <= 1'b0;
		end else begin
			o_tx_point <= tx_pt;
			if (!run) begin
				tx_bit_reg <= RECESSIVE;
			end else if (tx_pt) begin
				tx_bit_reg <= i_tx_bit;
			end
		end
	end
	// recessive at once in init or power-down
	assign o_can_tx = (init_ack_reg | i_power_down | ~enable_reg)
		? RECESSIVE : tx_bit_reg;

	// checks
	AST_CLOSED_NO_RXF: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(rxf_reg) |-> $past(mode_reg) != CAF_MODE_CLOSED)
		else $error("full flag set in closed mode");
	AST_TX_RECESSIVE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(init_ack_reg || i_power_down) |-> o_can_tx == RECESSIVE)
		else $error("transmit pin not recessive");
	AST_LOCK_BTR: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(apb_wr && i_paddr == CAF_OFS_BTR0 && !cfg_open) |=> $stable(btr0_reg))
		else $error("timing register changed while locked");
	AST_ENABLE_ONCE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(enable_wr_reg && !i_special_mode) |=> $stable(enable_reg))
		else $error("module enable changed twice");
	AST_HIT16_RANGE: assert property (@(posedge i_clk) disable iff (!i_rstn)
		($rose(rxf_reg) && mode_reg == CAF_MODE_16) |-> hit_reg <= 3'd3)
		else $error("hit index out of range in 16-bit mode");
	AST_HIT32_LOW: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(accept && mode_reg == CAF_MODE_32 && m32[3:0] == 4'hF)
		|=> rxf_reg && hit_reg == 3'd0)
		else $error("lowest filter not reported");
	AST_SYNC_ONE_TQ: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(run && tq_tick && seg_reg == CAF_SEG_SYNC) |=> seg_reg == CAF_SEG_ONE)
		else $error("sync segment longer than one quantum");
	AST_SEG1_MIN: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(tq_tick && seg1_last) |-> cnt_reg >= 5'(time_segment_one_field))
		else $error("segment one too short");
	AST_SEG2_MAX: assert property (@(posedge i_clk) disable iff (!i_rstn)
		(seg_reg == CAF_SEG_TWO) |-> cnt_reg <= 5'(time_segment_two_field))
		else $error("segment two too long");
endmodule
`default_nettype wire

// ==== caf_node_model.sv ====
// caf_node_model: far side of the block, the protocol engine
// handing over frames and the wired-and can line.
// assumes the bench asks for one frame at a time.
`timescale 1ns/1ps
`default_nettype none
module caf_node_model
	import caf_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// bench control
	input wire logic i_send,
	input wire caf_frame_t i_frame,
	input wire logic i_dom,
	// device side
	input wire logic i_can_tx,
	output logic o_rx_done,
	output caf_frame_t o_rx_frame,
	output logic o_can_rx
);
	// wired-and line: a dominant driver wins
	assign o_can_rx = i_can_tx & ~i_dom;
	// one-cycle delivery, frame scrambled once released
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_done <= 1'b0;
			o_rx_frame <= 32'h0000_0000;
		end else if (i_send) begin
			o_rx_done <= 1'b1;
			o_rx_frame <= i_frame;
		end else begin
			o_rx_done <= 1'b0;
			o_rx_frame <= ~o_rx_frame;
		end
	end
endmodule
`default_nettype wire

// ==== tb.sv ====
// tb: self-checking bench for caf_top, apb tasks and test sequences.
// assumes caf_node_model on the far side and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import caf_pkg::*;
	// filter case: mode, matching filters, mismatch xor, mask
	typedef struct {logic [1:0] m; logic [7:0] hm, xr, mk; logic ext;} caf_tc_t;
	// bench stimulus
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
	logic osc = 1'b0, pd = 1'b0, txb = 1'b1, send = 1'b0, dom = 1'b0;
	logic spm = 1'b0; // special system mode level
	logic [7:0] paddr = 8'h00, ab;
	logic [31:0] pwdata = 32'h0000_0000, rd, im;
	caf_frame_t frm = 32'h0000_0000, f;
	// design outputs
	wire logic [31:0] prdata;
	wire logic pready, pslverr, rx_done, tx_pt, smp_pt, rx_bit, can_rx;
	wire logic can_tx;
	wire caf_frame_t rx_frame, fg;
	int error_cnt = 0, checked = 0, cyc = 0, ltx = 0, per = 0, sofs = 0;
	int nb, hit, q;
	// frames under test
	localparam caf_frame_t FE = {1'b1, 1'b0, 1'b1, 29'h0ABC_1234};
	localparam caf_frame_t FS = {1'b0, 1'b1, 1'b0, 29'h0000_05A3};
	caf_tc_t tc[7] = '{'{0, 8'h02, 8'hFF, 8'h00, 1}, '{0, 8'h03, 8'hFF, 8'h00, 1},
		'{1, 8'h04, 8'h01, 8'h00, 0}, '{2, 8'h40, 8'h80, 8'h00, 1},
		'{2, 8'h00, 8'h0F, 8'h0F, 0}, '{2, 8'h00, 8'h10, 8'h0F, 0},
		'{3, 8'hFF, 8'h00, 8'h00, 1}};
	// timing rows: seg1 field, seg2 field, prescaler, clock source
	int t1[4] = '{3, 15, 9, 4};
	int t2[4] = '{2, 7, 1, 1};
	int ps[4] = '{0, 0, 1, 0};
	int cs[4] = '{1, 1, 1, 0};

	caf_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
		.i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslverr), .i_osc_tick(osc), .i_special_mode(spm),
		.i_power_down(pd), .i_bus_idle(1'b1), .i_rx_done(rx_done),
		.i_rx_frame(rx_frame), .i_rx_err_cnt(8'h3C), .i_tx_err_cnt(8'hA5),
		.i_tx_bit(txb), .o_tx_point(tx_pt), .o_sample_point(smp_pt),
		.o_rx_bit(rx_bit), .o_fg_frame(fg), .i_can_rx(can_rx),
		.o_can_tx(can_tx));
	caf_node_model node (.i_clk(i_clk), .i_rstn(i_rstn), .i_send(send),
		.i_frame(frm), .i_dom(dom), .i_can_tx(can_tx), .o_rx_done(rx_done),
		.o_rx_frame(rx_frame), .o_can_rx(can_rx));

	// clock
	always #5 i_clk = ~i_clk;
	// oscillator ticks, bit period monitor and watchdog
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		osc <= (cyc % 3 == 0);
		if (tx_pt === 1'b1) begin
			per <= cyc - ltx;
			ltx <= cyc;
		end
		if (smp_pt === 1'b1) sofs <= cyc - ltx;
		if (cyc == 30000) begin
			error_cnt++;
			stop_test();
		end
	end

	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// one apb transfer, read data and error taken at the pready edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge i_clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		pen <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	// request or leave initialization, wait for acknowledge
	task automatic init(input logic v);
		xfer(1'b1, CAF_OFS_CTL0, {31'h0, v});
		for (int i = 0; i < 40; i++) begin
			xfer(1'b0, CAF_OFS_CTL1, 32'h0000_0000);
			if (rd[0] === v) break;
		end
		chk({31'h0, rd[0]}, {31'h0, v});
	endtask
	// hand one frame to the far side model
	task automatic snd(input caf_frame_t x);
		@(posedge i_clk);
		send <= 1'b1;
		frm <= x;
		@(posedge i_clk);
		send <= 1'b0;
		repeat (3) @(posedge i_clk);
	endtask
	// identifier image bytes 0..3, byte 0 in the top
	function automatic logic [31:0] img(input caf_frame_t x);
		if (x.ide) return {x.id[28:21], x.id[20:18], x.srr, x.ide,
			x.id[17:15], x.id[14:7], x.id[6:0], x.rtr};
		return {x.id[10:3], x.id[2:0], x.rtr, x.ide, 3'b000, 16'h0000};
	endfunction
	// closing report
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge i_clk);
		i_rstn <= 1'b1;
		// reset state, block starts in initialization
		chk({31'h0, can_tx}, 32'h0000_0001);
		init(1'b1);
		xfer(1'b0, CAF_OFS_CTL0, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		xfer(1'b1, CAF_OFS_ERRC, 32'h0000_0000);
		xfer(1'b0, CAF_OFS_ERRC, 32'h0000_0000);
		chk(rd, 32'h0000_A53C);
		xfer(1'b0, 8'h60, 32'h0000_0000);
		chk({31'h0, er}, 32'h0000_0001);
		$display("reset and protection test done");
		// bit timing, compliant settings only
		for (int k = 0; k < 4; k++) begin
			init(1'b1);
			xfer(1'b1, CAF_OFS_CTL1, {24'h0, 1'b1, 1'(cs[k]), 6'h0});
			xfer(1'b1, CAF_OFS_BTR0, {24'h0, 2'b00, 6'(ps[k])});
			// compliant rows, triple sampling on the last
			xfer(1'b1, CAF_OFS_BTR1, {24'h0, 1'(k == 3), 3'(t2[k]), 4'(t1[k])});
			init(1'b0);
			repeat (400) @(posedge i_clk);
			q = (cs[k] == 1) ? (ps[k] + 1) : 3 * (ps[k] + 1);
			chk(per, q * (t1[k] + t2[k] + 3));
			chk(sofs, q * (t1[k] + 1));
		end
		$display("bit timing test done");
		// enable takes the first write only
		init(1'b1);
		xfer(1'b1, CAF_OFS_CTL1, 32'h0000_0040);
		xfer(1'b0, CAF_OFS_CTL1, 32'h0000_0000);
		chk(rd & 32'h0000_0080, 32'h0000_0080);
		// special mode may rewrite the enable bit
		spm <= 1'b1;
		xfer(1'b1, CAF_OFS_CTL1, 32'h0000_0040);
		xfer(1'b0, CAF_OFS_CTL1, 32'h0000_0000);
		chk(rd & 32'h0000_0080, 32'h0000_0000);
		xfer(1'b1, CAF_OFS_CTL1, 32'h0000_00C0);
		xfer(1'b0, CAF_OFS_CTL1, 32'h0000_0000);
		chk(rd & 32'h0000_0080, 32'h0000_0080);
		spm <= 1'b0;
		// filter modes
		for (int k = 0; k < 7; k++) begin
			f = tc[k].ext ? FE : FS;
			im = img(f);
			nb = (tc[k].m == 2'd3) ? 1 : (4 >> tc[k].m);
			hit = -1;
			for (int j = 8 / nb - 1; j >= 0; j--)
				if (tc[k].hm[j] || (tc[k].xr & ~tc[k].mk) == 8'h00) hit = j;
			if (tc[k].m == 2'd3) hit = -1;
			init(1'b1);
			xfer(1'b1, CAF_OFS_IDAC, 32'(tc[k].m) << 4);
			for (int i = 0; i < 8; i++) begin
				ab = im[31 - 8 * (i % nb) -: 8];
				if (!tc[k].hm[i / nb]) ab = ab ^ tc[k].xr;
				xfer(1'b1, 8'(CAF_OFS_ACC + 4 * i), {24'h0, ab});
				xfer(1'b1, 8'(CAF_OFS_MSK + 4 * i), {24'h0, tc[k].mk});
			end
			init(1'b0);
			snd(f);
			xfer(1'b0, CAF_OFS_RFLG, 32'h0000_0000);
			chk(rd & 32'h0000_0001, (hit >= 0) ? 1 : 0);
			if (hit >= 0) begin
				xfer(1'b0, CAF_OFS_IDAC, 32'h0000_0000);
				chk(rd & 32'h37, (32'(tc[k].m) << 4) | hit);
				chk(fg, f);
				snd(~f);
				chk(fg, f);
				xfer(1'b1, CAF_OFS_RFLG, 32'h0000_0001);
			end
		end
		$display("filter test done");
		// configuration locked while on-line
		xfer(1'b0, CAF_OFS_ACC, 32'h0000_0000);
		im = rd;
		xfer(1'b1, CAF_OFS_ACC, ~im & 32'h0000_00FF);
		xfer(1'b0, CAF_OFS_ACC, 32'h0000_0000);
		chk(rd, im);
		xfer(1'b0, CAF_OFS_BTR0, 32'h0000_0000);
		im = rd;
		xfer(1'b1, CAF_OFS_BTR0, ~im & 32'h0000_00FF);
		xfer(1'b0, CAF_OFS_BTR0, 32'h0000_0000);
		chk(rd, im);
		// another node dominates the line, then releases it
		dom <= 1'b1;
		repeat (80) @(posedge i_clk);
		chk({31'h0, rx_bit}, 32'h0000_0000);
		chk({31'h0, can_tx}, 32'h0000_0001);
		dom <= 1'b0;
		repeat (80) @(posedge i_clk);
		chk({31'h0, rx_bit}, 32'h0000_0001);
		// dominant bit out and back in, then forced recessive
		txb <= 1'b0;
		repeat (80) @(posedge i_clk);
		chk({31'h0, can_tx}, 32'h0000_0000);
		chk({31'h0, rx_bit}, 32'h0000_0000);
		pd <= 1'b1;
		@(posedge i_clk);
		#1 chk({31'h0, can_tx}, 32'h0000_0001);
		@(posedge i_clk);
		pd <= 1'b0;
		init(1'b1);
		chk({31'h0, can_tx}, 32'h0000_0001);
		$display("transmit pin test done");
		stop_test();
	end
endmodule
`default_nettype wire
